//--- tpwm_timer.sv
/*
 * 16-bit free-running timer: PWM, one-pulse, compare, capture, interrupt gating.
 * Assumes pins arrive asynchronously; low-power state comes from the system core.
 */
//
// Function
// - PWM: counter reloads FFFCh on second compare match, setting period.
// - PWM: pin one takes level one on match one, level two on match two.
// - Level one=1, level two=0: high pulse lasts compare two minus compare one.
// - Equal level bits keep pin one constant at that level in PWM.
// - High byte write suspends that compare until low byte is written.
// - PWM never sets either compare flag.
// - PWM: capture flag one set at second compare match; gated interrupt.
// - PWM disconnects capture pin one; capture pin two still works.
// - PWM and one-pulse both set: only PWM acts.
// - Wait state leaves timer untouched; interrupt enabled by bit 7, 6 or 5 wakes device.
// - Halt stops counter; resumes on interrupt wake, reset restarts it.
// - Capture edge during halt arms; interrupt wake sets flag, stores count.
// - All events share one interrupt; each gated by own enable and mask.
// - Capture enable bit 7 requests interrupt when either capture flag set.
// - Compare enable bit 6 requests interrupt when either compare flag set.
// - Overflow enable bit 5 allows interrupt when overflow flag set.
// - Force two bit 4 copies level two onto pin two if enabled.
// - Force one bit 3 copies level one onto pin one if enabled.
// - Level two bit 2 to pin two on match; pin one in pulse modes.
// - Edge bit 1 selects capture edge on pin one: 0 fall, 1 rise.
// - PWM compare writes take effect only at end of period.
// - Clock field selects CPU clock /4, /2, /8 or external clock.
// - Level one bit 0 to pin one on each first compare match.
`default_nettype none
module tpwm_timer
  import tpwm_pkg::*;
(
  input  wire logic       clk,          // 25 MHz clock
  input  wire logic       rst_n,        // Synchronous reset, active low
  input  wire logic [3:0] addr,         // Register index
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output logic      [7:0] rdata,        // Read data, cycle after rd
  input  wire logic       wait_req,     // Core in wait state
  input  wire logic       halt_req,     // Core in halt state
  input  wire logic       cap1_pin,     // First capture pin
  input  wire logic       cap2_pin,     // Second capture pin
  input  wire logic       ext_clk_pin,  // External timer clock pin
  output logic            cmp1_pin,     // First compare pin value
  output logic            cmp1_oe,      // First compare pin enable
  output logic            cmp2_pin,     // Second compare pin value
  output logic            cmp2_oe,      // Second compare pin enable
  output logic            timer_irq,    // Shared timer interrupt
  output logic            wake_ff       // Wake request from wait state
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  cr1_ff;
  logic [7:0]  cr2_ff;
  logic [1:0]  ctl3_ff;
  logic [15:0] cmp1_ff;
  logic [15:0] cmp2_ff;
  logic [15:0] act1_ff;
  logic [15:0] act2_ff;
  logic [15:0] cnt_ff;
  logic [15:0] ic1_ff;
  logic [15:0] ic2_ff;
  logic [7:0]  hi1_ff;
  logic [7:0]  hi2_ff;
  logic        inh1_ff;
  logic        inh2_ff;
  logic        first_capture_flag_ff;
  logic        second_capture_flag_ff;
  logic        first_compare_flag_ff;
  logic        second_compare_flag_ff;
  logic        tof_ff;
  logic        sr_rd_ff;
  logic [2:0]  pre_ff;
  logic [2:0]  s1_ff;
  logic [2:0]  s2_ff;
  logic [2:0]  se_ff;
  logic [2:0]  hist_ok_ff;
  logic        arm1_ff;
  logic        arm2_ff;
  tpwm_pwr_e   pwr_ff;
  logic        was_halt_ff;

  // Edge of the stable bit against its history
  function automatic logic edge_hit(input logic [2:0] s, input logic rise);
    edge_hit = rise ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers: [0] first stage, [1] stable, [2] history
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      se_ff <= 3'h0;
      hist_ok_ff <= 3'h0;
    end else begin
      // No edges until history holds real samples; idle-high pins
      // would otherwise show a false rising edge after reset
      hist_ok_ff <= {hist_ok_ff[1:0], 1'b1};
      s1_ff <= {s1_ff[1:0], cap1_pin};
      s2_ff <= {s2_ff[1:0], cap2_pin};
      se_ff <= {se_ff[1:0], ext_clk_pin};
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic        pwm_on;
  logic        opm_on;
  logic        halted;
  logic        tick;
  logic        m1;
  logic        m2;
  logic        e1;
  logic        e2;
  logic        wr_lo1;
  logic        wr_lo2;
  logic        sr_clr;
  logic        rd_ok;
  logic        pend_cap;
  logic        pend_cmp;
  logic        pend_ovf;
  assign pwm_on = cr2_ff[B_PWM];
  assign opm_on = cr2_ff[B_ONEP] & ~pwm_on;
  assign halted = (pwr_ff == TPWM_HALT);
  assign e1 = edge_hit(s1_ff, cr1_ff[B_EDGE1]) & hist_ok_ff[2] & ~pwm_on;
  assign e2 = edge_hit(s2_ff, cr2_ff[B_EDGE2]) & hist_ok_ff[2];
  assign wr_lo1 = wr & (addr == A_C1L);
  assign wr_lo2 = wr & (addr == A_C2L);
  assign rd_ok = rd | wr;
  assign sr_clr = sr_rd_ff;

  // ----------------------------------------------------------------
  // Prescaler / external clock select
  // ----------------------------------------------------------------
  always_comb begin
    case (cr2_ff[B_CC_HI:B_CC_LO])
      CC_DIV4: tick = (pre_ff & DIV4_TC) == DIV4_TC;
      CC_DIV2: tick = (pre_ff & DIV2_TC) == DIV2_TC;
      CC_DIV8: tick = pre_ff == DIV8_TC;
      default: tick = edge_hit(se_ff, cr2_ff[B_EXEDGE]) & hist_ok_ff[2];
    endcase
  end

  // ----------------------------------------------------------------
  // Matches only on timer ticks and while not inhibited
  // ----------------------------------------------------------------
  assign m1 = tick & ~halted & ~inh1_ff & (cnt_ff == (pwm_on ? act1_ff : cmp1_ff));
  assign m2 = tick & ~halted & ~inh2_ff & (cnt_ff == (pwm_on ? act2_ff : cmp2_ff));

  always_ff @(posedge clk) begin
    if (!rst_n) pre_ff <= 3'h0;
    else if (!halted) pre_ff <= pre_ff + 3'h1;
  end

  // ----------------------------------------------------------------
  // Power state and wake
  // ----------------------------------------------------------------
  assign pend_cap = cr1_ff[B_CAP_IE] & (first_capture_flag_ff | second_capture_flag_ff);
  assign pend_cmp = cr1_ff[B_CMP_IE] & (first_compare_flag_ff | second_compare_flag_ff);
  assign pend_ovf = cr1_ff[B_OVF_IE] & tof_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_ff      <= TPWM_RUN;
      was_halt_ff <= 1'b0;
      wake_ff     <= 1'b0;
    end else begin
      case (pwr_ff)
        TPWM_RUN:  pwr_ff <= halt_req ? TPWM_HALT : (wait_req ? TPWM_WAIT : TPWM_RUN);
        TPWM_WAIT: pwr_ff <= wait_req ? TPWM_WAIT : TPWM_RUN;
        TPWM_HALT: pwr_ff <= halt_req ? TPWM_HALT : TPWM_RUN;
        default:   pwr_ff <= TPWM_RUN;
      endcase
      was_halt_ff <= halted;
      wake_ff <= (pwr_ff == TPWM_WAIT) & ~ctl3_ff[B_GMASK]
                 & (pend_cap | pend_cmp | pend_ovf);
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_ff <= RST_CNT;
    else if (wr & (addr == A_CNTL)) cnt_ff <= RST_CNT;
    else if (m2 & pwm_on) cnt_ff <= RELOAD_CNT;
    else if (opm_on & e1) cnt_ff <= RELOAD_CNT;
    else if (tick & ~halted) cnt_ff <= cnt_ff + 16'h1;
  end

  // ----------------------------------------------------------------
  // Control registers and compare buffers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cr1_ff  <= RST_CR1;
      cr2_ff  <= RST_CR2;
      ctl3_ff <= RST_CTL3;
    end else if (wr) begin
      if (addr == A_CR1) cr1_ff <= wdata;
      if (addr == A_CR2) cr2_ff <= wdata;
      if (addr == A_CTL3) ctl3_ff <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp1_ff <= RST_CMP;
      cmp2_ff <= RST_CMP;
      hi1_ff  <= RST_CMP[15:8];
      hi2_ff  <= RST_CMP[15:8];
      inh1_ff <= 1'b0;
      inh2_ff <= 1'b0;
    end else begin
      if (wr & (addr == A_C1H)) begin
        hi1_ff  <= wdata;
        inh1_ff <= 1'b1;
      end else if (wr_lo1) begin
        cmp1_ff <= {hi1_ff, wdata};
        inh1_ff <= 1'b0;
      end
      if (wr & (addr == A_C2H)) begin
        hi2_ff  <= wdata;
        inh2_ff <= 1'b1;
      end else if (wr_lo2) begin
        cmp2_ff <= {hi2_ff, wdata};
        inh2_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Active copies used in PWM, loaded at end of period
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act1_ff <= RST_CMP;
      act2_ff <= RST_CMP;
    end else if (!pwm_on || m2) begin
      act1_ff <= cmp1_ff;
      act2_ff <= cmp2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Captures, with arming during halt
  // ----------------------------------------------------------------
  logic exit_halt;
  assign exit_halt = was_halt_ff & ~halted;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm1_ff <= 1'b0;
      arm2_ff <= 1'b0;
      ic1_ff  <= 16'h0;
      ic2_ff  <= 16'h0;
    end else begin
      arm1_ff <= halted ? (arm1_ff | e1) : 1'b0;
      arm2_ff <= halted ? (arm2_ff | e2) : 1'b0;
      if (m2 & pwm_on) ic1_ff <= cnt_ff;
      else if ((e1 & ~halted & ~opm_on) | (exit_halt & arm1_ff)) ic1_ff <= cnt_ff;
      else if (opm_on & e1) ic1_ff <= RELOAD_CNT + 16'h1;
      if ((e2 & ~halted) | (exit_halt & arm2_ff)) ic2_ff <= cnt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Flags: set wins over clear; clear is status read then low access
  // ----------------------------------------------------------------
  logic        set_first_capture_flag;
  logic        set_second_capture_flag;
  logic        set_first_compare_flag;
  logic        set_second_compare_flag;
  logic        set_tof;
  assign set_first_capture_flag = (m2 & pwm_on) | (e1 & ~halted) | (exit_halt & arm1_ff);
  assign set_second_capture_flag = (e2 & ~halted) | (exit_halt & arm2_ff);
  assign set_first_compare_flag = m1 & ~pwm_on & ~opm_on & ~cr1_ff[B_FORCE1];
  assign set_second_compare_flag = m2 & ~pwm_on & ~cr1_ff[B_FORCE2];
  assign set_tof  = tick & ~halted & (cnt_ff == 16'hffff) & ~(m2 & pwm_on);

  // Status read must be the last access before the low byte
  always_ff @(posedge clk) begin
    if (!rst_n) sr_rd_ff <= 1'b0;
    else if (rd & (addr == A_SR)) sr_rd_ff <= 1'b1;
    else if (rd_ok) sr_rd_ff <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {first_capture_flag_ff, second_capture_flag_ff, first_compare_flag_ff, second_compare_flag_ff, tof_ff} <= 5'h0;
    end else begin
      first_capture_flag_ff <= set_first_capture_flag | (first_capture_flag_ff & ~(sr_clr & rd_ok & (addr == A_IC1L)));
      second_capture_flag_ff <= set_second_capture_flag | (second_capture_flag_ff & ~(sr_clr & rd_ok & (addr == A_IC2L)));
      first_compare_flag_ff <= set_first_compare_flag | (first_compare_flag_ff & ~(sr_clr & rd_ok & (addr == A_C1L)));
      second_compare_flag_ff <= set_second_compare_flag | (second_compare_flag_ff & ~(sr_clr & rd_ok & (addr == A_C2L)));
      tof_ff  <= set_tof  | (tof_ff  & ~(sr_clr & rd_ok & (addr == A_CNTL)));
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) timer_irq <= 1'b0;
    else timer_irq <= ~ctl3_ff[B_GMASK] & (pend_cap | pend_cmp | pend_ovf
                      | (ctl3_ff[B_CAP2_IE] & second_capture_flag_ff));
  end

  // ----------------------------------------------------------------
  // Compare pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp1_pin <= 1'b0;
      cmp2_pin <= 1'b0;
      cmp1_oe  <= 1'b0;
      cmp2_oe  <= 1'b0;
    end else begin
      cmp1_oe <= cr2_ff[B_OE1];
      cmp2_oe <= cr2_ff[B_OE2];
      if (pwm_on) begin
        if (m2) cmp1_pin <= cr1_ff[B_LVL2];
        else if (m1) cmp1_pin <= cr1_ff[B_LVL1];
      end else if (opm_on) begin
        if (e1) cmp1_pin <= cr1_ff[B_LVL2];
        else if (m1) cmp1_pin <= cr1_ff[B_LVL1];
      end else if (cr1_ff[B_FORCE1]) begin
        cmp1_pin <= cr1_ff[B_LVL1];
      end else if (m1) begin
        cmp1_pin <= cr1_ff[B_LVL1];
      end
      if (cr1_ff[B_FORCE2] & ~pwm_on & ~opm_on) cmp2_pin <= cr1_ff[B_LVL2];
      else if (m2 & ~pwm_on & ~opm_on) cmp2_pin <= cr1_ff[B_LVL2];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        A_CR1:  rdata <= cr1_ff;
        A_CR2:  rdata <= cr2_ff;
        A_SR:   rdata <= {first_capture_flag_ff, first_compare_flag_ff, tof_ff, second_capture_flag_ff, second_compare_flag_ff, 3'h0};
        A_C1H:  rdata <= cmp1_ff[15:8];
        A_C1L:  rdata <= cmp1_ff[7:0];
        A_C2H:  rdata <= cmp2_ff[15:8];
        A_C2L:  rdata <= cmp2_ff[7:0];
        A_CNTH: rdata <= cnt_ff[15:8];
        A_CNTL: rdata <= cnt_ff[7:0];
        A_IC1H: rdata <= ic1_ff[15:8];
        A_IC1L: rdata <= ic1_ff[7:0];
        A_IC2H: rdata <= ic2_ff[15:8];
        A_IC2L: rdata <= ic2_ff[7:0];
        A_CTL3: rdata <= {6'h0, ctl3_ff};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tpwm_pkg.sv
/*
 * Constants for the 16-bit timer with PWM, compare, capture and interrupt gating.
 * Assumes a single 25 MHz clock domain and a plain register port.
 */
`default_nettype none
package tpwm_pkg;
  // ----------------------------------------------------------------
  // Register map (byte index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CR1   = 4'h0;
  localparam logic [3:0] A_CR2   = 4'h1;
  localparam logic [3:0] A_SR    = 4'h2;
  localparam logic [3:0] A_C1H   = 4'h3;
  localparam logic [3:0] A_C1L   = 4'h4;
  localparam logic [3:0] A_C2H   = 4'h5;
  localparam logic [3:0] A_C2L   = 4'h6;
  localparam logic [3:0] A_CNTH  = 4'h7;
  localparam logic [3:0] A_CNTL  = 4'h8;
  localparam logic [3:0] A_IC1H  = 4'h9;
  localparam logic [3:0] A_IC1L  = 4'ha;
  localparam logic [3:0] A_IC2H  = 4'hb;
  localparam logic [3:0] A_IC2L  = 4'hc;
  localparam logic [3:0] A_CTL3  = 4'hd;
  // ----------------------------------------------------------------
  // First control register fields
  // ----------------------------------------------------------------
  localparam int B_CAP_IE  = 7;
  localparam int B_CMP_IE  = 6;
  localparam int B_OVF_IE  = 5;
  localparam int B_FORCE2  = 4;
  localparam int B_FORCE1  = 3;
  localparam int B_LVL2    = 2;
  localparam int B_EDGE1   = 1;
  localparam int B_LVL1    = 0;
  // ----------------------------------------------------------------
  // Second control register fields
  // ----------------------------------------------------------------
  localparam int B_OE1     = 7;
  localparam int B_OE2     = 6;
  localparam int B_ONEP    = 5;
  localparam int B_PWM     = 4;
  localparam int B_CC_HI   = 3;
  localparam int B_CC_LO   = 2;
  localparam int B_EDGE2   = 1;
  localparam int B_EXEDGE  = 0;
  // Own third control register: capture-two enable and global mask
  localparam int B_CAP2_IE = 0;
  localparam int B_GMASK   = 1;
  // ----------------------------------------------------------------
  // Reset and reload values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CR1    = 8'h00;
  localparam logic [7:0]  RST_CR2    = 8'h00;
  localparam logic [1:0]  RST_CTL3   = 2'h2;
  localparam logic [15:0] RST_CMP    = 16'h8000;
  localparam logic [15:0] RST_CNT    = 16'hfffc;
  localparam logic [15:0] RELOAD_CNT = 16'hfffc;
  localparam logic [2:0]  DIV4_TC    = 3'h3;
  localparam logic [2:0]  DIV2_TC    = 3'h1;
  localparam logic [2:0]  DIV8_TC    = 3'h7;
  localparam logic [1:0]  CC_DIV4    = 2'h0;
  localparam logic [1:0]  CC_DIV2    = 2'h1;
  localparam logic [1:0]  CC_DIV8    = 2'h2;
  localparam logic [1:0]  CC_EXT     = 2'h3;

  typedef enum logic [1:0] {
    TPWM_RUN  = 2'b00,
    TPWM_WAIT = 2'b01,
    TPWM_HALT = 2'b10
  } tpwm_pwr_e;
endpackage
`default_nettype wire

//--- tpwm_timer_properties.sv
/* Port-level checker for tpwm_timer.
   Assumes a bind into tpwm_timer, one clock and a synchronous reset. */
`default_nettype none
module tpwm_timer_properties
  import tpwm_pkg::*;
(
  input wire logic       clk,        // Clock
  input wire logic       rst_n,      // Reset, active low
  input wire logic [3:0] addr,       // Register index
  input wire logic [7:0] wdata,      // Write data
  input wire logic       wr,         // Write strobe
  input wire logic       rd,         // Read strobe
  input wire logic [7:0] rdata,      // Read data
  input wire logic       wait_req,   // Wait state
  input wire logic       cmp1_pin,   // Pin one
  input wire logic       cmp1_oe,    // Pin one enable
  input wire logic       cmp2_pin,   // Pin two
  input wire logic       cmp2_oe,    // Pin two enable
  input wire logic       timer_irq,  // Interrupt
  input wire logic       wake_ff     // Wake request
);
  // ------
  // Shadows of written control registers
  // ------
  logic [7:0] cr1_ff;
  logic [7:0] cr2_ff;
  logic [1:0] ctl3_ff;
  logic       cr1_wr;
  logic       cr2_wr;
  logic       f1_ok;
  logic       f2_ok;
  assign cr1_wr = wr && addr == A_CR1;
  assign cr2_wr = wr && addr == A_CR2;
  assign f1_ok  = cr2_ff[B_OE1] && !cr2_ff[B_PWM] && !cr2_ff[B_ONEP];
  assign f2_ok  = cr2_ff[B_OE2] && !cr2_ff[B_PWM] && !cr2_ff[B_ONEP];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cr1_ff  <= RST_CR1;
      cr2_ff  <= RST_CR2;
      ctl3_ff <= RST_CTL3;
    end else if (wr) begin
      if (addr == A_CR1) cr1_ff <= wdata;
      if (addr == A_CR2) cr2_ff <= wdata;
      if (addr == A_CTL3) ctl3_ff <= wdata[1:0];
    end
  end
  // ------
  // Properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_oe_copy_lag: assert property (cr2_wr ##1 !cr2_wr |-> ##1
    cmp1_oe == $past(wdata[B_OE1], 2) && cmp2_oe == $past(wdata[B_OE2], 2))
    else $error("pin enables do not follow control write");
  a_wake_needs_wait: assert property (wake_ff |-> $past(wait_req) || $past(wait_req, 2))
    else $error("wake without wait state");
  a_wake_needs_irq: assert property (wake_ff |-> timer_irq)
    else $error("wake without enabled interrupt");
  a_irq_needs_unmask: assert property (timer_irq |-> !$past(ctl3_ff[B_GMASK]))
    else $error("interrupt while masked");
  a_irq_needs_enable: assert property (timer_irq |->
    $past(cr1_ff[7:5] != 3'h0 || ctl3_ff[B_CAP2_IE]))
    else $error("interrupt with no enable set");
  a_force_pin_one: assert property (cr1_wr && wdata[B_FORCE1] && f1_ok |->
    ##[1:10] cmp1_pin == cr1_ff[B_LVL1])
    else $error("forced level missing on pin one");
  a_force_pin_two: assert property (cr1_wr && wdata[B_FORCE2] && f2_ok |->
    ##[1:10] cmp2_pin == cr1_ff[B_LVL2])
    else $error("forced level missing on pin two");
  a_equal_level_hold: assert property (cr2_ff[B_PWM] && !cr1_wr && !cr2_wr &&
    cr1_ff[B_LVL1] == cr1_ff[B_LVL2] && cmp1_pin == cr1_ff[B_LVL1] |=> $stable(cmp1_pin))
    else $error("pin one moved with equal levels");
  a_pwm_no_cmp_flag: assert property (rd && addr == A_SR && cr2_ff[B_PWM] |=>
    rdata[6] == 1'b0 && rdata[3] == 1'b0)
    else $error("compare flag set in pulse mode");
  c_pwm_status: cover property (rd && addr == A_SR && cr2_ff[B_PWM]);
  c_irq_raised: cover property (timer_irq);
  c_wake_raised: cover property (wake_ff);
endmodule

bind tpwm_timer tpwm_timer_properties tpwm_timer_properties_inst (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .wait_req(wait_req), .cmp1_pin(cmp1_pin), .cmp1_oe(cmp1_oe),
  .cmp2_pin(cmp2_pin), .cmp2_oe(cmp2_oe), .timer_irq(timer_irq), .wake_ff(wake_ff)
);
`default_nettype wire

//--- tpwm_pin_model.sv
/* Far-side pin model: capture pins, a still external clock, and a
   monitor of the high time on compare pin one.
   Assumes requests change at rising edges of clk. */
`default_nettype none
module tpwm_pin_model (
  input  wire logic        clk,          // Clock
  input  wire logic        cap1_req,     // Wanted capture one level
  input  wire logic        cap2_req,     // Wanted capture two level
  input  wire logic        cmp1_pin,     // Compare pin one
  input  wire logic        cmp1_oe,      // Compare pin one enable
  output logic             cap1_pin,     // Capture pin one
  output logic             cap2_pin,     // Capture pin two
  output logic             ext_clk_pin,  // External clock, still
  output logic      [15:0] hi_len        // Last high time, clocks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_ff;
  initial begin
    cap1_pin    = 1'b0;
    cap2_pin    = 1'b1;
    ext_clk_pin = 1'b0;
    hi_len      = 16'h0000;
    run_ff      = 16'h0000;
  end
  // Pins move half a period away from the sampling edge
  always @(negedge clk) begin
    cap1_pin <= cap1_req;
    cap2_pin <= cap2_req;
  end
  always @(posedge clk) begin
    if (cmp1_oe && cmp1_pin) begin
      run_ff <= run_ff + 16'h0001;
    end else begin
      if (run_ff != 16'h0000) hi_len <= run_ff;
      run_ff <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

//--- tpwm_timer_test.sv
/* Self-checking bench for tpwm_timer.
   Assumes the pin model and the bound checker are compiled with it. */
`default_nettype none
module tpwm_timer_test
  import tpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       w;
    logic [3:0] a;
    logic [7:0] d;
  } tpwm_row_s;
  localparam logic [15:0] C1V    = 16'h0008;
  localparam logic [15:0] C2V    = 16'h0010;
  localparam logic [15:0] EXP_HI = (C2V - C1V) * ({13'h0000, DIV2_TC} + 16'h0001);
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        wait_req = 1'b0;
  logic        halt_req = 1'b0;
  logic        cap1_req = 1'b0;
  logic        cap2_req = 1'b1;
  logic [7:0]  rdata;
  logic        cap1_pin, cap2_pin, ext_clk_pin, cmp1_pin, cmp1_oe, cmp2_pin, cmp2_oe;
  logic        timer_irq, wake_ff;
  logic [15:0] hi_len;
  logic [7:0]  v, v2, exp1;
  int          err_count = 0;
  int          compares = 0;
  int          bad;
  tpwm_row_s   rows [12] = '{'{1'b0, A_CR1, 8'h00}, '{1'b0, A_CR2, 8'h00},
    '{1'b0, A_SR, 8'h00}, '{1'b0, A_C1H, 8'h80}, '{1'b0, A_C1L, 8'h00},
    '{1'b0, A_C2H, 8'h80}, '{1'b0, A_C2L, 8'h00}, '{1'b0, A_CTL3, 8'h02},
    '{1'b0, 4'he, 8'h00}, '{1'b1, A_CR1, 8'ha5}, '{1'b0, A_CR1, 8'ha5},
    '{1'b1, A_CR1, 8'h00}};
  logic [7:0]  fcr [4] = '{8'h08, 8'h14, 8'h09, 8'h10};
  logic [1:0]  fpin [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  always #20 clk = ~clk;
  tpwm_timer tpwm_timer_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wait_req(wait_req), .halt_req(halt_req),
    .cap1_pin(cap1_pin), .cap2_pin(cap2_pin), .ext_clk_pin(ext_clk_pin),
    .cmp1_pin(cmp1_pin), .cmp1_oe(cmp1_oe), .cmp2_pin(cmp2_pin), .cmp2_oe(cmp2_oe),
    .timer_irq(timer_irq), .wake_ff(wake_ff));
  tpwm_pin_model tpwm_pin_model_inst (.clk(clk), .cap1_req(cap1_req),
    .cap2_req(cap2_req), .cmp1_pin(cmp1_pin), .cmp1_oe(cmp1_oe), .cap1_pin(cap1_pin),
    .cap2_pin(cap2_pin), .ext_clk_pin(ext_clk_pin), .hi_len(hi_len));
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus_wr(rows[i].a, rows[i].d);
      end else begin
        bus_rd(rows[i].a, v);
        check("register", {8'h00, rows[i].d}, {8'h00, v});
      end
    end
    // ------
    // Pulse mode, both mode bits set, divide by two
    // ------
    bus_wr(A_CNTL, 8'h00);
    bus_wr(A_C2H, C2V[15:8]);
    bus_wr(A_C2L, C2V[7:0]);
    bus_wr(A_C1H, C1V[15:8]);
    bus_wr(A_C1L, C1V[7:0]);
    bus_wr(A_CR1, 8'h01);
    bus_wr(A_CR2, 8'hb4);
    for (int k = 0; k < 400 && hi_len == 16'h0000; k++) @(posedge clk);
    check("pulse width", EXP_HI, hi_len);
    bus_rd(A_SR, v);
    check("status in pulse mode", 16'h0080, {8'h00, v & 8'hc8});
    check("irq masked", 16'h0000, {15'h0000, timer_irq});
    bus_wr(A_CTL3, 8'h00);
    repeat (4) @(posedge clk);
    check("irq no enable", 16'h0000, {15'h0000, timer_irq});
    bus_wr(A_CR1, 8'h21);
    repeat (4) @(posedge clk);
    check("irq overflow", 16'h0001, {15'h0000, timer_irq});
    bus_wr(A_CR1, 8'h81);
    repeat (4) @(posedge clk);
    check("irq enabled", 16'h0001, {15'h0000, timer_irq});
    wait_req <= 1'b1;
    repeat (4) @(posedge clk);
    check("wake", 16'h0001, {15'h0000, wake_ff});
    wait_req <= 1'b0;
    cap2_req <= 1'b0;
    repeat (8) @(posedge clk);
    bus_rd(A_SR, v);
    check("capture two", 16'h0010, {8'h00, v & 8'h10});
    bus_wr(A_CR1, 8'h85);
    repeat (60) @(posedge clk);
    bad = 0;
    repeat (60) begin
      @(posedge clk);
      if (cmp1_pin !== 1'b1) bad++;
    end
    check("steady level", 16'h0000, bad[15:0]);
    @(posedge clk);
    halt_req <= 1'b1;
    repeat (2) @(posedge clk);
    bus_rd(A_CNTL, v);
    repeat (20) @(posedge clk);
    bus_rd(A_CNTL, v2);
    check("halted count", {8'h00, v}, {8'h00, v2});
    @(posedge clk);
    halt_req <= 1'b0;
    // ------
    // Forced levels away from any match, then capture edges and compare irq, divide by eight
    // ------
    bus_wr(A_CR2, 8'hc8);
    bus_wr(A_CNTL, 8'h00);
    foreach (fcr[i]) begin
      bus_wr(A_CR1, fcr[i]);
      repeat (12) @(posedge clk);
      check("forced pins", {14'h0000, fpin[i]}, {14'h0000, cmp1_pin, cmp2_pin});
    end
    for (int e = 0; e < 2; e++) begin
      bus_wr(A_CR1, {6'h00, e[0], 1'b0});
      repeat (2) begin
        bus_rd(A_SR, v);
        bus_rd(A_IC1L, v);
        exp1 = (cap1_req != e[0]) ? 8'h80 : 8'h00;
        @(posedge clk);
        cap1_req <= ~cap1_req;
        repeat (8) @(posedge clk);
        bus_rd(A_SR, v);
        check("capture one edge", {8'h00, exp1}, {8'h00, v & 8'h80});
      end
    end
    bus_wr(A_CR1, 8'h40);
    repeat (4) @(posedge clk);
    check("irq compare", 16'h0001, {15'h0000, timer_irq});
    end_sim();
  end
endmodule
`default_nettype wire
